// File: design/epc_eprom_ctrl.sv
// EPROM array, program control register, option cells and boot entry
// Summary of operation
// RQ1 - 2048 user bytes from 1600 to 1DFF
// RQ2 - Sixteen vector bytes, lowest four for test
// RQ3 - Boot ROM region 1E00 to 1FEF, separate
// RQ4 - Boot mode caught at reset release
// RQ5 - Boot routine paced one millisecond per byte
// RQ6 - Source image maps byte for byte
// RQ7 - Program control register sits at 3E
// RQ8 - Option cell programs only when enabled
// RQ9 - Latched writes capture address and data
// RQ10 - Array unreadable while latch enabled
// RQ11 - Power bit needs latch bit set
// RQ12 - Software programming sequence order
// RQ13 - Power and latch cleared separately
// RQ14 - Option cells survive reset, erase 1F
// RQ15 - Trigger bit selects edge only
// RQ16 - Pull bit connects port pulls
// RQ17 - Port interrupt bit disables port A
// RQ18 - Oscillator bit picks 128 or 4064
// RQ19 - Control register resets to zero
`timescale 1ns/1ps
module epc_eprom_ctrl #(
  parameter int BOOT_BYTE_CYC = epc_pkg::BOOT_BYTE_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // CPU memory bus
  input wire logic [12:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  output logic [7:0] o_cpu_rdata,
  output logic o_cpu_hit,
  // Boot ROM contents and UV erase
  input wire logic [7:0] i_boot_rom_rdata,
  input wire logic i_erase,
  // Mode pins
  input wire logic i_boot_test_level,
  input wire logic i_boot_select_pin,
  output logic o_boot_mode,
  output logic o_boot_byte_tick,
  // Programming and option outputs
  output logic o_program_power_on,
  output logic o_interrupt_trigger_select,
  output logic o_pull_resistor_connect,
  output logic o_port_interrupt_disable,
  output logic o_lvr_enable,
  output logic [11:0] o_osc_delay_cycles
);

  function automatic logic f_in(input logic [12:0] a, input logic [12:0] lo,
                                input logic [12:0] hi);
    f_in = (a >= lo) && (a <= hi);
  endfunction : f_in

  logic [7:0] user_mem [0:epc_pkg::USER_BYTES-1];
  logic [7:0] vec_mem [0:epc_pkg::VEC_BYTES-1];
  logic [7:0] opt_q;
  logic opt_en_q;
  logic latch_q;
  logic power_q;
  logic [12:0] lat_addr_q;
  logic [7:0] lat_data_q;
  logic lat_valid_q;
  logic rst_prev_q;
  logic boot_q;
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic [7:0] rdata_q;
  logic hit_q;
  logic [7:0] pcr_rd;
  logic in_user;
  logic in_vec;
  logic in_boot;
  logic in_opt;
  logic in_pcr;
  logic [10:0] user_idx;
  logic [3:0] vec_idx;
  logic [10:0] lat_user_idx;
  logic [3:0] lat_vec_idx;

  // RQ1 RQ2 RQ3 region decode
  assign in_user = f_in(i_cpu_addr, epc_pkg::USER_LO, epc_pkg::USER_HI);
  assign in_vec = f_in(i_cpu_addr, epc_pkg::VEC_LO, epc_pkg::VEC_HI);
  assign in_boot = f_in(i_cpu_addr, epc_pkg::BOOT_LO, epc_pkg::BOOT_HI);
  // RQ7 register address
  assign in_pcr = (i_cpu_addr == epc_pkg::PCR_ADDR);
  assign in_opt = (i_cpu_addr == epc_pkg::OPT_ADDR);
  assign user_idx = 11'(i_cpu_addr - epc_pkg::USER_LO);
  assign vec_idx = i_cpu_addr[3:0];
  assign lat_user_idx = 11'(lat_addr_q - epc_pkg::USER_LO);
  assign lat_vec_idx = lat_addr_q[3:0];
  // RQ19 reserved bits read zero
  assign pcr_rd = {4'h0, opt_en_q, latch_q, power_q, 1'b0};

  // RQ19 control register write and reset
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      opt_en_q <= epc_pkg::PCR_RESET[epc_pkg::PCR_OPT_EN_BIT];
      latch_q <= epc_pkg::PCR_RESET[epc_pkg::PCR_LATCH_BIT];
      power_q <= epc_pkg::PCR_RESET[epc_pkg::PCR_POWER_BIT];
    end
    else if (i_cpu_wr && in_pcr)
    begin
      opt_en_q <= i_cpu_wdata[epc_pkg::PCR_OPT_EN_BIT];
      latch_q <= i_cpu_wdata[epc_pkg::PCR_LATCH_BIT];
      // RQ11 power forced off without latch
      power_q <= i_cpu_wdata[epc_pkg::PCR_POWER_BIT] & i_cpu_wdata[epc_pkg::PCR_LATCH_BIT];
    end
  end

  // RQ9 address and data latches
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      lat_addr_q <= 13'h0000;
      lat_data_q <= 8'h00;
      lat_valid_q <= 1'b0;
    end
    else if (!latch_q)
    begin
      lat_valid_q <= 1'b0;
    end
    else if (i_cpu_wr && (in_user || in_vec || in_opt))
    begin
      lat_addr_q <= i_cpu_addr;
      lat_data_q <= i_cpu_wdata;
      lat_valid_q <= 1'b1;
    end
  end

  // RQ11 cells take the latched byte only while powered; erase restores blank
  always_ff @(posedge i_clk)
  begin
    if (i_erase)
    begin
      for (int i = 0; i < epc_pkg::USER_BYTES; i++)
      begin
        user_mem[i] <= epc_pkg::CELL_ERASED;
      end
      for (int j = 0; j < epc_pkg::VEC_BYTES; j++)
      begin
        vec_mem[j] <= epc_pkg::CELL_ERASED;
      end
    end
    else if (power_q && lat_valid_q)
    begin
      if (f_in(lat_addr_q, epc_pkg::USER_LO, epc_pkg::USER_HI))
      begin
        user_mem[lat_user_idx] <= lat_data_q;
      end
      else if (f_in(lat_addr_q, epc_pkg::VEC_LO, epc_pkg::VEC_HI))
      begin
        vec_mem[lat_vec_idx] <= lat_data_q;
      end
    end
  end

  // RQ14 option cells ignore reset
  always_ff @(posedge i_clk)
  begin
    if (i_erase)
    begin
      opt_q <= epc_pkg::OPT_ERASED;
    end
    // RQ8 option programming gated by enable
    else if (power_q && lat_valid_q && opt_en_q && (lat_addr_q == epc_pkg::OPT_ADDR))
    begin
      opt_q <= lat_data_q & epc_pkg::OPT_MASK;
    end
  end

  // RQ15 RQ16 RQ17 RQ18 option decode to outputs
  always_ff @(posedge i_clk)
  begin
    o_interrupt_trigger_select <= opt_q[epc_pkg::OPT_TRIG_BIT];
    o_pull_resistor_connect <= opt_q[epc_pkg::OPT_PULL_BIT];
    o_port_interrupt_disable <= opt_q[epc_pkg::OPT_PINT_BIT];
    o_lvr_enable <= opt_q[epc_pkg::OPT_LVR_BIT];
    o_osc_delay_cycles <= opt_q[epc_pkg::OPT_OSC_BIT] ? epc_pkg::OSC_SHORT : epc_pkg::OSC_LONG;
  end

  // RQ4 mode caught on reset release
  always_ff @(posedge i_clk)
  begin
    rst_prev_q <= i_srst;
    if (rst_prev_q && !i_srst)
    begin
      boot_q <= i_boot_test_level && !i_boot_select_pin;
    end
    else if (i_srst)
    begin
      boot_q <= 1'b0;
    end
  end

  // RQ5 per-byte pacing tick for the boot routine
  always_ff @(posedge i_clk)
  begin
    if (i_srst || !boot_q)
    begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == 16'(BOOT_BYTE_CYC - 1))
    begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // RQ10 array and option reads blocked while latched; data one cycle after request
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end
    else if (i_cpu_rd)
    begin
      hit_q <= in_user || in_vec || in_boot || in_opt || in_pcr;
      if (in_pcr)
      begin
        rdata_q <= pcr_rd;
      end
      else if ((in_user || in_vec || in_opt) && latch_q)
      begin
        rdata_q <= 8'h00;
      end
      else if (in_user)
      begin
        rdata_q <= user_mem[user_idx];
      end
      else if (in_vec)
      begin
        rdata_q <= vec_mem[vec_idx];
      end
      else if (in_opt)
      begin
        rdata_q <= opt_q;
      end
      else if (in_boot)
      begin
        rdata_q <= i_boot_rom_rdata;
      end
      else
      begin
        rdata_q <= 8'h00;
      end
    end
    else
    begin
      hit_q <= 1'b0;
      rdata_q <= 8'h00;
    end
  end

  assign o_cpu_rdata = rdata_q;
  assign o_cpu_hit = hit_q;
  assign o_boot_mode = boot_q;
  assign o_boot_byte_tick = tick_q;
  assign o_program_power_on = power_q;

  a_power_needs_latch: assert property (@(posedge i_clk) disable iff (i_srst)
    power_q |-> latch_q) else $error("power on without latch"); // RQ11
  a_pcr_reset_zero: assert property (@(posedge i_clk)
    $past(i_srst) |-> (pcr_rd == 8'h00)) else $error("control not cleared"); // RQ19
  a_pcr_readback: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_cpu_rd && in_pcr) |=> (o_cpu_rdata[7:4] == 4'h0 && o_cpu_rdata[0] == 1'b0))
    else $error("reserved bits not zero"); // RQ19
  a_locked_read_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_cpu_rd && in_user && latch_q) |=> (o_cpu_rdata == 8'h00))
    else $error("array readable while latched"); // RQ10
  a_latch_capture: assert property (@(posedge i_clk) disable iff (i_srst)
    (latch_q && i_cpu_wr && in_user) |=> (lat_valid_q && lat_addr_q == $past(i_cpu_addr)
    && lat_data_q == $past(i_cpu_wdata))) else $error("latch missed write"); // RQ9
  a_opt_guard: assert property (@(posedge i_clk) disable iff (i_srst || i_erase)
    !opt_en_q |=> $stable(opt_q)) else $error("option changed while disabled"); // RQ8
  a_opt_high_zero: assert property (@(posedge i_clk)
    i_erase |=> (opt_q == epc_pkg::OPT_ERASED)) else $error("bad erased option"); // RQ14
  a_osc_select: assert property (@(posedge i_clk) disable iff (i_srst)
    ##1 (o_osc_delay_cycles == ($past(opt_q[1]) ? 12'h080 : 12'hFE0)))
    else $error("oscillator delay mismatch"); // RQ18
  a_trig_follow: assert property (@(posedge i_clk) disable iff (i_srst)
    ##1 (o_interrupt_trigger_select == $past(opt_q[4]) &&
    o_port_interrupt_disable == $past(opt_q[2]) && o_pull_resistor_connect == $past(opt_q[3])))
    else $error("option outputs mismatch"); // RQ15
  a_boot_entry: assert property (@(posedge i_clk)
    ($past(i_srst) && !i_srst) |=> (boot_q == $past(i_boot_test_level && !i_boot_select_pin)))
    else $error("boot mode not caught"); // RQ4
  a_tick_single: assert property (@(posedge i_clk) disable iff (i_srst)
    tick_q |=> !tick_q) else $error("tick longer than one cycle"); // RQ5
  a_hit_regions: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_cpu_rd && in_boot) |=> (o_cpu_hit && o_cpu_rdata == $past(i_boot_rom_rdata)))
    else $error("boot region read wrong"); // RQ3

  c_program_byte: cover property (@(posedge i_clk) disable iff (i_srst)
    latch_q && lat_valid_q && power_q);
  c_boot_entry: cover property (@(posedge i_clk) boot_q && tick_q);
  c_opt_program: cover property (@(posedge i_clk) disable iff (i_srst)
    power_q && opt_en_q && lat_addr_q == epc_pkg::OPT_ADDR);

endmodule : epc_eprom_ctrl

// File: design/epc_pkg.sv
// Constants for the EPROM program control block
package epc_pkg;
  localparam int ADDR_W = 13;
  localparam logic [12:0] USER_LO = 13'h1600;
  localparam logic [12:0] USER_HI = 13'h1DFF;
  localparam logic [12:0] BOOT_LO = 13'h1E00;
  localparam logic [12:0] BOOT_HI = 13'h1FEF;
  localparam logic [12:0] VEC_LO = 13'h1FF0;
  localparam logic [12:0] VEC_HI = 13'h1FFF;
  localparam logic [12:0] VEC_RSV_HI = 13'h1FF3;
  localparam logic [12:0] PCR_ADDR = 13'h003E;
  localparam logic [12:0] OPT_ADDR = 13'h01FF;
  localparam int USER_BYTES = 2048;
  localparam int VEC_BYTES = 16;
  localparam int PCR_OPT_EN_BIT = 3;
  localparam int PCR_LATCH_BIT = 2;
  localparam int PCR_POWER_BIT = 1;
  localparam logic [7:0] PCR_RESET = 8'h00;
  localparam logic [7:0] PCR_MASK = 8'h0E;
  localparam int OPT_TRIG_BIT = 4;
  localparam int OPT_PULL_BIT = 3;
  localparam int OPT_PINT_BIT = 2;
  localparam int OPT_OSC_BIT = 1;
  localparam int OPT_LVR_BIT = 0;
  localparam logic [7:0] OPT_ERASED = 8'h1F;
  localparam logic [7:0] OPT_MASK = 8'h1F;
  localparam logic [7:0] CELL_ERASED = 8'h00;
  localparam logic [11:0] OSC_SHORT = 12'h080;
  localparam logic [11:0] OSC_LONG = 12'hFE0;
  localparam int CLK_HZ = 25000000;
  localparam int BOOT_BYTE_TIME_US = 1000;
  localparam int BOOT_BYTE_CYC = (CLK_HZ / 1000000) * BOOT_BYTE_TIME_US;
endpackage : epc_pkg

// File: tb/eprom_program_control_tb_top.sv
// Self-checking bench for the EPROM program control block
`timescale 1ns/1ps
module eprom_program_control_tb_top;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [12:0] i_cpu_addr = 13'h0000;
  logic [7:0] i_cpu_wdata = 8'h00;
  logic i_cpu_wr = 1'b0;
  logic i_cpu_rd = 1'b0;
  logic [7:0] i_boot_rom_rdata = 8'h5A;
  logic i_erase = 1'b1;
  logic i_boot_test_level = 1'b0;
  logic i_boot_select_pin = 1'b1;
  logic [7:0] o_cpu_rdata;
  logic o_cpu_hit;
  logic o_boot_mode;
  logic o_boot_byte_tick;
  logic o_program_power_on;
  logic o_interrupt_trigger_select;
  logic o_pull_resistor_connect;
  logic o_port_interrupt_disable;
  logic o_lvr_enable;
  logic [11:0] o_osc_delay_cycles;
  int mismatches = 0;
  int tests_run = 0;

  always #20 i_clk = ~i_clk;

  // Short byte time keeps the boot pacing check quick
  epc_eprom_ctrl #(.BOOT_BYTE_CYC(8)) epc_eprom_ctrl_inst (
    .i_clk, .i_srst, .i_cpu_addr, .i_cpu_wdata, .i_cpu_wr, .i_cpu_rd,
    .o_cpu_rdata, .o_cpu_hit, .i_boot_rom_rdata, .i_erase,
    .i_boot_test_level, .i_boot_select_pin, .o_boot_mode, .o_boot_byte_tick,
    .o_program_power_on, .o_interrupt_trigger_select, .o_pull_resistor_connect,
    .o_port_interrupt_disable, .o_lvr_enable, .o_osc_delay_cycles
  );

  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic lvl, input logic sel);
    @(posedge i_clk);
    i_boot_test_level <= lvl;
    i_boot_select_pin <= sel;
    i_srst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : do_reset

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_cpu_wr <= 1'b1;
    i_cpu_addr <= a;
    i_cpu_wdata <= d;
    @(posedge i_clk);
    i_cpu_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [12:0] a, input logic [7:0] d, input logic h);
    @(posedge i_clk);
    i_cpu_rd <= 1'b1;
    i_cpu_addr <= a;
    @(posedge i_clk);
    i_cpu_rd <= 1'b0;
    #1;
    chk(o_cpu_rdata, d, "read data");
    chk(o_cpu_hit, h, "read hit");
  endtask : rchk

  // Full byte program; en sets the option cell enable
  task automatic prog(input logic [12:0] a, input logic [7:0] d, input logic en);
    wr(epc_pkg::PCR_ADDR, {4'h0, en, 3'b100});
    wr(a, d);
    wr(epc_pkg::PCR_ADDR, {4'h0, en, 3'b110});
    repeat (2) @(posedge i_clk);
    #1;
    chk(o_program_power_on, 1'b1, "power on");
    wr(epc_pkg::PCR_ADDR, {4'h0, en, 3'b100});
    wr(epc_pkg::PCR_ADDR, 8'h00);
    repeat (2) @(posedge i_clk);
    #1;
    chk(o_program_power_on, 1'b0, "power off");
  endtask : prog

  task automatic opts(input logic [4:0] o, input logic [11:0] osc);
    repeat (3) @(posedge i_clk);
    #1;
    chk(o_interrupt_trigger_select, o[4], "trigger");
    chk(o_pull_resistor_connect, o[3], "pulls");
    chk(o_port_interrupt_disable, o[2], "port int");
    chk(o_osc_delay_cycles, osc, "osc delay");
    chk(o_lvr_enable, o[0], "lvr");
  endtask : opts

  task automatic t_reg;
    rchk(13'h003E, 8'h00, 1'b1);
    wr(13'h003E, 8'hFF);
    rchk(13'h003E, 8'h0E, 1'b1);
    wr(13'h003E, 8'h02);
    rchk(13'h003E, 8'h00, 1'b1);
    chk(o_program_power_on, 1'b0, "power without latch");
    $display("t_reg done");
  endtask : t_reg

  task automatic t_map;
    logic [12:0] ad [4] = '{13'h1600, 13'h1DFF, 13'h1FF0, 13'h1FFF};
    rchk(13'h0000, 8'h00, 1'b0);
    rchk(13'h15FF, 8'h00, 1'b0);
    rchk(13'h1E00, 8'h5A, 1'b1);
    rchk(13'h1FEF, 8'h5A, 1'b1);
    wr(13'h1601, 8'h33);
    rchk(13'h1601, 8'h00, 1'b1);
    wr(13'h1E00, 8'h77);
    rchk(13'h1E00, 8'h5A, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      prog(ad[i], 8'hA1 + 8'(i), 1'b0);
      rchk(ad[i], 8'hA1 + 8'(i), 1'b1);
    end
    wr(13'h003E, 8'h04);
    rchk(13'h1600, 8'h00, 1'b1);
    rchk(13'h01FF, 8'h00, 1'b1);
    rchk(13'h1FFF, 8'h00, 1'b1);
    wr(13'h003E, 8'h00);
    rchk(13'h1600, 8'hA1, 1'b1);
    $display("t_map done");
  endtask : t_map

  task automatic t_opt;
    opts(5'h1F, 12'h080);
    prog(13'h01FF, 8'h00, 1'b0);
    rchk(13'h01FF, 8'h1F, 1'b1);
    prog(13'h01FF, 8'h15, 1'b1);
    rchk(13'h01FF, 8'h15, 1'b1);
    opts(5'h15, 12'hFE0);
    prog(13'h01FF, 8'h0A, 1'b1);
    opts(5'h0A, 12'h080);
    do_reset(1'b0, 1'b1);
    rchk(13'h01FF, 8'h0A, 1'b1);
    $display("t_opt done");
  endtask : t_opt

  // Bounded wait for the next byte tick; returns cycles waited
  task automatic wait_tick(output int n);
    n = 0;
    while (o_boot_byte_tick !== 1'b1 && n < 40)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n == 40)
    begin
      mismatches++;
      $display("ERROR %0t: no byte tick", $time);
      stop_test();
    end
  endtask : wait_tick

  task automatic t_boot;
    int n;
    do_reset(1'b1, 1'b0);
    chk(o_boot_mode, 1'b1, "boot entry");
    wait_tick(n);
    @(posedge i_clk);
    #1;
    wait_tick(n);
    chk(12'(n + 1), 12'h008, "tick spacing");
    do_reset(1'b1, 1'b1);
    chk(o_boot_mode, 1'b0, "select high");
    do_reset(1'b0, 1'b0);
    chk(o_boot_mode, 1'b0, "no test level");
    $display("t_boot done");
  endtask : t_boot

  initial
  begin
    // Cells power up unknown; erase under reset so option outputs settle first
    @(posedge i_clk);
    i_erase <= 1'b0;
    do_reset(1'b0, 1'b1);
    t_reg();
    t_map();
    t_opt();
    t_boot();
    stop_test();
  end
endmodule : eprom_program_control_tb_top
